// ---- logic/ofl_consts.svh ----
// constants for the glyph RAM loader
`ifndef OFL_CONSTS_SVH
`define OFL_CONSTS_SVH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define OFL_OFF_WIDTH 8'h00
`define OFL_OFF_HEIGHT 8'h04
`define OFL_OFF_SC_HIGH 8'h08
`define OFL_OFF_SC_LOW 8'h0C
`define OFL_OFF_CODE_HIGH 8'h10
`define OFL_OFF_CODE_LOW 8'h14
`define OFL_OFF_BIT_MASK 8'h18
`define OFL_OFF_DATA_PORT 8'h1C
`define OFL_OFF_BIT_ADDR 8'h20
// -----------------------------------------------------------------
// fields, limits and reset values
// -----------------------------------------------------------------
`define OFL_STOP_BIT 7
`define OFL_MIN_SIZE 6'h08
`define OFL_MAX_SIZE 6'h20
`define OFL_RST_SIZE 6'h08
`define OFL_RST_SC 9'h000
`define OFL_RST_MASK 8'hFF
`define OFL_RAM_BITS 22'h00_8000
`define OFL_STEP 22'h00_0008
`define OFL_SLIDER_RES 11'h010
`define OFL_GRADES 9'h011
// -----------------------------------------------------------------
// glyph code map
// -----------------------------------------------------------------
`define OFL_GEN_FIRST 9'h160
`define OFL_SL_H_START 9'h1D2
`define OFL_SL_V_START 9'h1F6
`define OFL_SL_H_END 9'h1E3
`define OFL_SL_V_END 9'h1E4
`define OFL_SL_MID_FIRST 9'h1E5
// -----------------------------------------------------------------
// element property word fields
// -----------------------------------------------------------------
`define OFL_PW_RAM 9
`define OFL_PW_FG 13:10
`define OFL_PW_BG 17:14
`define OFL_PW_PAL 19:18
`endif

// ---- logic/ofl_pkg.sv ----
// types shared by the glyph RAM loader
package ofl_pkg;
  typedef logic [8:0] ofl_code_t;
  typedef logic [21:0] ofl_baddr_t;
  typedef logic [22:0] ofl_prop_t;
  typedef enum logic [1:0] {
    OFL_SRC_ROM = 2'b00,
    OFL_SRC_GEN = 2'b01,
    OFL_SRC_RAM = 2'b11
  } ofl_src_e;
  typedef enum logic [1:0] {
    OFL_SL_NONE = 2'b00,
    OFL_SL_START = 2'b01,
    OFL_SL_MID = 2'b11,
    OFL_SL_END = 2'b10
  } ofl_slp_e;
endpackage

// ---- logic/ofl_font_loader.sv ----
// glyph RAM loader with APB registers and pixel fetch port
// Function
// - slider start 1D2/1F6, end 1E3/1E4
// - middle glyphs: 16 pixels, 17 grades
// - grades scaled to displayed glyph width
// - 4 kbyte writable glyph storage
// - glyph width and height limited 8..32
// - one bit mono, two bits multi
// - mono 0 background, 1 foreground
// - multi pixel picks palette entry
// - glyph codes are nine bits
// - data bytes MSB first, row order
// - codes below start code are multicolour
// - code write recomputes bit base address
// - data write advances address by eight
// - only mask-enabled bits are written
// - stop flag masks beyond glyph end
// - stop clear keeps address packing on
// - data port stays addressed in bursts
// - writes accepted while display runs
// - element glyph code from property word
`timescale 1ns/1ns
`include "ofl_consts.svh"
module ofl_font_loader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic disp_req,
  input wire ofl_pkg::ofl_prop_t element_property_word,
  input wire logic [4:0] disp_px,
  input wire logic [4:0] disp_py,
  output logic disp_valid,
  output ofl_pkg::ofl_src_e disp_source,
  output logic [3:0] disp_colour,
  output ofl_pkg::ofl_slp_e disp_slider_part,
  output logic disp_slider_fill
);
  import ofl_pkg::*;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [5:0] glyph_width_reg;
  logic [5:0] glyph_height_reg;
  ofl_code_t mono_start_code_reg;
  logic [7:0] glyph_code_high_reg;
  logic [7:0] glyph_code_low_reg;
  logic [7:0] glyph_bit_mask_reg;
  ofl_baddr_t bit_addr_reg;
  ofl_baddr_t glyph_end_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] ram_even [0:511];
  logic [31:0] ram_odd [0:511];

  function automatic logic [5:0] clamp_size(input logic [7:0] v);
    if (v < 8'(`OFL_MIN_SIZE)) begin
      return `OFL_MIN_SIZE;
    end
    if (v > 8'(`OFL_MAX_SIZE)) begin
      return `OFL_MAX_SIZE;
    end
    return v[5:0];
  endfunction

  // first bit of a glyph: multi glyphs packed from 0, mono after them
  function automatic ofl_baddr_t glyph_base(input ofl_code_t c, input ofl_code_t sc,
                                            input logic [10:0] area);
    if (c < sc) begin
      return 22'(22'(c) * 22'(area) * 22'd2);
    end
    return 22'(22'(sc) * 22'(area) * 22'd2 + 22'(c - sc) * 22'(area));
  endfunction

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  wire acc_wait = psel & penable & ~pready_reg;
  wire acc_done = psel & penable & pready_reg;
  wire wr_done = acc_done & pwrite;
  wire hit_w = paddr == `OFL_OFF_WIDTH;
  wire hit_h = paddr == `OFL_OFF_HEIGHT;
  wire hit_sch = paddr == `OFL_OFF_SC_HIGH;
  wire hit_scl = paddr == `OFL_OFF_SC_LOW;
  wire hit_cch = paddr == `OFL_OFF_CODE_HIGH;
  wire hit_ccl = paddr == `OFL_OFF_CODE_LOW;
  wire hit_msk = paddr == `OFL_OFF_BIT_MASK;
  wire hit_dat = paddr == `OFL_OFF_DATA_PORT;
  wire hit_ba = paddr == `OFL_OFF_BIT_ADDR;
  wire hit_any = hit_w | hit_h | hit_sch | hit_scl | hit_cch | hit_ccl | hit_msk
                 | hit_dat | hit_ba;
  wire bad_acc = ~hit_any | (pwrite & hit_ba);
  wire code_wr = wr_done & (hit_cch | hit_ccl);
  wire data_wr = wr_done & hit_dat;
  wire [31:0] rd_mux =
    hit_w ? {26'h000_0000, glyph_width_reg} :
    hit_h ? {26'h000_0000, glyph_height_reg} :
    hit_sch ? {31'h0000_0000, mono_start_code_reg[8]} :
    hit_scl ? {24'h00_0000, mono_start_code_reg[7:0]} :
    hit_cch ? {24'h00_0000, glyph_code_high_reg} :
    hit_ccl ? {24'h00_0000, glyph_code_low_reg} :
    hit_msk ? {24'h00_0000, glyph_bit_mask_reg} :
    hit_ba ? {10'h000, bit_addr_reg} : 32'h0000_0000;

  // -----------------------------------------------------------------
  // glyph code and base address
  // -----------------------------------------------------------------
  wire [10:0] glyph_area = 11'(glyph_width_reg) * 11'(glyph_height_reg);
  wire [7:0] code_high_next = (wr_done & hit_cch) ? pwdata[7:0] : glyph_code_high_reg;
  wire [7:0] code_low_next = (wr_done & hit_ccl) ? pwdata[7:0] : glyph_code_low_reg;
  wire [8:0] code_next = {code_high_next[0], code_low_next};
  wire code_next_multi = code_next < mono_start_code_reg;
  wire [21:0] base_next = glyph_base(code_next, mono_start_code_reg, glyph_area);
  wire [21:0] len_next = code_next_multi ? 22'({glyph_area, 1'b0}) : 22'(glyph_area);
  wire stop_flag = glyph_code_high_reg[`OFL_STOP_BIT];

  // -----------------------------------------------------------------
  // write masking: user mask, end of glyph, end of storage
  // -----------------------------------------------------------------
  wire [21:0] bits_left = glyph_end_reg - bit_addr_reg;
  wire past_end = bit_addr_reg >= glyph_end_reg;
  wire [7:0] stop_mask = ~stop_flag ? 8'hFF :
                         past_end ? 8'h00 :
                         (bits_left >= `OFL_STEP) ? 8'hFF :
                         ~(8'hFF >> bits_left[3:0]);
  wire in_ram = bit_addr_reg < `OFL_RAM_BITS;
  wire [7:0] eff_mask = in_ram ? (glyph_bit_mask_reg & stop_mask) : 8'h00;

  // byte lands MSB first at the bit address, may straddle two words
  wire [4:0] woff = bit_addr_reg[4:0];
  wire [9:0] widx = bit_addr_reg[14:5];
  wire [63:0] win_d = {pwdata[7:0], 56'h00_0000_0000_0000} >> woff;
  wire [63:0] win_m = {eff_mask, 56'h00_0000_0000_0000} >> woff;
  wire lo_ok = widx != 10'h3FF;
  wire [8:0] even_idx = widx[0] ? 9'(widx[9:1] + 9'h001) : widx[9:1];
  wire [8:0] odd_idx = widx[9:1];
  wire [31:0] even_d = widx[0] ? win_d[31:0] : win_d[63:32];
  wire [31:0] even_m = widx[0] ? (lo_ok ? win_m[31:0] : 32'h0000_0000) : win_m[63:32];
  wire [31:0] odd_d = widx[0] ? win_d[63:32] : win_d[31:0];
  wire [31:0] odd_m = widx[0] ? win_m[63:32] : win_m[31:0];

  // -----------------------------------------------------------------
  // APB slave and register file
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= acc_wait;
      pslverr_reg <= acc_wait & bad_acc;
      prdata_reg <= (acc_wait & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glyph_width_reg <= `OFL_RST_SIZE;
      glyph_height_reg <= `OFL_RST_SIZE;
      mono_start_code_reg <= `OFL_RST_SC;
      glyph_code_high_reg <= 8'h00;
      glyph_code_low_reg <= 8'h00;
      glyph_bit_mask_reg <= `OFL_RST_MASK;
    end else if (wr_done) begin
      if (hit_w) begin
        glyph_width_reg <= clamp_size(pwdata[7:0]);
      end
      if (hit_h) begin
        glyph_height_reg <= clamp_size(pwdata[7:0]);
      end
      if (hit_sch) begin
        mono_start_code_reg[8] <= pwdata[0];
      end
      if (hit_scl) begin
        mono_start_code_reg[7:0] <= pwdata[7:0];
      end
      glyph_code_high_reg <= code_high_next;
      glyph_code_low_reg <= code_low_next;
      if (hit_msk) begin
        glyph_bit_mask_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_addr_reg <= 22'h00_0000;
      glyph_end_reg <= 22'h00_0000;
    end else if (code_wr) begin
      bit_addr_reg <= base_next;
      glyph_end_reg <= 22'(base_next + len_next);
    end else if (data_wr) begin
      bit_addr_reg <= 22'(bit_addr_reg + `OFL_STEP);
    end
  end

  // storage is two banks so a straddling byte is one write; the fetch
  // port reads independently, so the display never waits
  always_ff @(posedge pclk) begin
    if (data_wr) begin
      ram_even[even_idx] <= (ram_even[even_idx] & ~even_m) | (even_d & even_m);
      ram_odd[odd_idx] <= (ram_odd[odd_idx] & ~odd_m) | (odd_d & odd_m);
    end
  end

  // -----------------------------------------------------------------
  // pixel fetch
  // -----------------------------------------------------------------
  wire [8:0] pcode = element_property_word[8:0];
  wire p_ram = element_property_word[`OFL_PW_RAM];
  wire p_multi = pcode < mono_start_code_reg;
  wire [21:0] p_lin = 22'(22'(disp_py) * 22'(glyph_width_reg) + 22'(disp_px));
  wire [21:0] p_addr = 22'(glyph_base(pcode, mono_start_code_reg, glyph_area)
                       + (p_multi ? 22'({p_lin[20:0], 1'b0}) : p_lin));
  wire [9:0] p_widx = p_addr[14:5];
  wire [31:0] p_word = p_widx[0] ? ram_odd[p_widx[9:1]] : ram_even[p_widx[9:1]];
  wire [31:0] p_shift = p_word << p_addr[4:0];
  wire mono_px = p_shift[31];
  wire [3:0] prop_fg = element_property_word[`OFL_PW_FG];
  wire [3:0] prop_bg = element_property_word[`OFL_PW_BG];
  wire [1:0] prop_pal = element_property_word[`OFL_PW_PAL];
  wire [3:0] mono_col = mono_px ? prop_fg : prop_bg;
  wire [3:0] multi_col = {prop_pal, p_shift[31:30]};
  wire [3:0] ram_col = p_multi ? multi_col : mono_col;
  wire ofl_src_e p_src = p_ram ? OFL_SRC_RAM :
                         (pcode < `OFL_GEN_FIRST) ? OFL_SRC_ROM : OFL_SRC_GEN;

  // slider parts; fill scaled from 16-pixel grades to the real width
  wire sl_start = (pcode == `OFL_SL_H_START) | (pcode == `OFL_SL_V_START);
  wire sl_end = (pcode == `OFL_SL_H_END) | (pcode == `OFL_SL_V_END);
  wire [8:0] sl_grade = 9'(pcode - `OFL_SL_MID_FIRST);
  wire sl_mid = (pcode >= `OFL_SL_MID_FIRST) & (sl_grade < `OFL_GRADES);
  wire [10:0] sl_pos = 11'(11'(disp_px) * `OFL_SLIDER_RES);
  wire [10:0] sl_lim = 11'(11'(sl_grade[4:0]) * 11'(glyph_width_reg));
  wire sl_fill = sl_mid & (sl_pos < sl_lim);
  wire ofl_slp_e sl_part = p_ram ? OFL_SL_NONE :
                           sl_start ? OFL_SL_START :
                           sl_end ? OFL_SL_END :
                           sl_mid ? OFL_SL_MID : OFL_SL_NONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_valid <= 1'b0;
      disp_source <= OFL_SRC_ROM;
      disp_colour <= 4'h0;
      disp_slider_part <= OFL_SL_NONE;
      disp_slider_fill <= 1'b0;
    end else begin
      disp_valid <= disp_req;
      disp_source <= p_src;
      disp_colour <= p_ram ? ram_col : 4'h0;
      disp_slider_part <= sl_part;
      disp_slider_fill <= sl_fill;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence data_write_s;
    data_wr & ~code_wr;
  endsequence
  sequence code_write_s;
    code_wr;
  endsequence
  sequence multi_code_s;
    code_wr & code_next_multi;
  endsequence
  sequence mono_code_s;
    code_wr & ~code_next_multi;
  endsequence

  addr_step_a: assert property (
    data_write_s |=> bit_addr_reg == $past(bit_addr_reg) + 22'd8)
    else $error("bit address did not advance by eight");
  base_load_a: assert property (
    code_write_s |=> bit_addr_reg == glyph_base(
      {glyph_code_high_reg[0], glyph_code_low_reg}, mono_start_code_reg, glyph_area))
    else $error("base address not recomputed");
  size_range_a: assert property (
    glyph_width_reg >= 6'd8 && glyph_width_reg <= 6'd32 &&
    glyph_height_reg >= 6'd8 && glyph_height_reg <= 6'd32)
    else $error("glyph size out of range");
  mask_subset_a: assert property (
    data_wr |-> (eff_mask & ~glyph_bit_mask_reg) == 8'h00)
    else $error("masked bit written");
  stop_block_a: assert property (
    data_wr && stop_flag && past_end |-> eff_mask == 8'h00)
    else $error("write past glyph end not masked");
  mono_col_a: assert property (
    disp_req && p_ram && !p_multi |=>
      disp_colour == ($past(mono_px) ? $past(prop_fg) : $past(prop_bg)))
    else $error("mono pixel colour wrong");
  multi_pal_a: assert property (
    disp_req && p_ram && p_multi |=> disp_colour[3:2] == $past(prop_pal))
    else $error("multicolour palette wrong");
  slider_start_a: assert property (
    disp_req && !p_ram && (pcode == 9'h1D2 || pcode == 9'h1F6) |=>
      disp_slider_part == OFL_SL_START)
    else $error("slider start code missed");
  fetch_valid_a: assert property (
    disp_req ##1 data_wr |-> disp_valid)
    else $error("fetch stalled by host write");
  full_grade_a: assert property (
    disp_req && !p_ram && pcode == 9'h1F5 && disp_px < glyph_width_reg |=> disp_slider_fill)
    else $error("full grade not filled");
  multi_span_a: assert property (
    multi_code_s |=> 22'(glyph_end_reg - bit_addr_reg) == 22'({glyph_area, 1'b0}))
    else $error("multicolour glyph span wrong");
  mono_span_a: assert property (
    mono_code_s |=> 22'(glyph_end_reg - bit_addr_reg) == 22'(glyph_area))
    else $error("single colour glyph span wrong");
  stop_free_a: assert property (
    data_wr && !stop_flag && in_ram |-> eff_mask == glyph_bit_mask_reg)
    else $error("mask changed without stop flag");
  stop_tail_a: assert property (
    data_wr && stop_flag && bits_left == 22'h00_0001 |-> stop_mask == 8'h80)
    else $error("last glyph bit not kept alone");
  addr_hold_a: assert property (
    !code_wr && !data_wr |=> $stable(bit_addr_reg))
    else $error("bit address moved without a write");
  slider_end_a: assert property (
    disp_req && !p_ram && (pcode == 9'h1E3 || pcode == 9'h1E4) |=>
      disp_slider_part == OFL_SL_END)
    else $error("slider end code missed");
  mid_part_a: assert property (
    disp_req && !p_ram && pcode >= 9'h1E5 && pcode <= 9'h1F5 |=>
      disp_slider_part == OFL_SL_MID)
    else $error("slider middle grade missed");
  empty_grade_a: assert property (
    disp_req && !p_ram && pcode == 9'h1E5 |=> !disp_slider_fill)
    else $error("empty grade filled");
  src_rom_a: assert property (
    disp_req && !p_ram && pcode < 9'h160 |=>
      disp_source == OFL_SRC_ROM)
    else $error("rom source missed");
  src_gen_a: assert property (
    disp_req && !p_ram && pcode >= 9'h160 |=>
      disp_source == OFL_SRC_GEN)
    else $error("generator source missed");
  src_ram_a: assert property (
    disp_req && p_ram |=> disp_source == OFL_SRC_RAM)
    else $error("ram source missed");
  valid_rise_a: assert property (
    disp_req |=> disp_valid)
    else $error("fetch answer missing");
  valid_fall_a: assert property (
    !disp_req |=> !disp_valid)
    else $error("fetch answer without request");
  width_clamp_a: assert property (
    wr_done && hit_w && pwdata[7:0] > 8'h20 |=> glyph_width_reg == 6'h20)
    else $error("glyph width not clamped");
  height_clamp_a: assert property (
    wr_done && hit_h && pwdata[7:0] < 8'h08 |=> glyph_height_reg == 6'h08)
    else $error("glyph height not clamped");
endmodule

// ---- dv/ofl_host_model.sv ----
// host side model that performs apb register transfers
`timescale 1ns/1ns
module ofl_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // ----------------------------------------------------------------
  // one transfer: setup, access held until pready, then release
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the glyph ram loader
`timescale 1ns/1ns
`include "ofl_consts.svh"
module tb;
  import ofl_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, disp_valid, disp_slider_fill, err_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic disp_req = 1'h0;
  ofl_prop_t element_property_word = 23'h00_0000;
  logic [4:0] disp_px = 5'h00;
  logic [4:0] disp_py = 5'h00;
  ofl_src_e disp_source;
  logic [3:0] disp_colour;
  ofl_slp_e disp_slider_part;
  int n_errors = 0;
  int checks_done = 0;
  logic [8:0] pat = 9'h15F;
  logic [8:0] sl_code [0:7] = '{9'h1D2, 9'h1F6, 9'h1E3, 9'h1E4, 9'h1ED, 9'h1ED, 9'h1F5, 9'h1E5};
  logic [1:0] sl_part [0:7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
  logic [4:0] sl_px [0:7] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h04, 5'h05, 5'h08, 5'h00};
  logic sl_fill [0:7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};

  always #5 pclk = ~pclk;

  ofl_font_loader uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disp_req(disp_req), .element_property_word(element_property_word),
    .disp_px(disp_px), .disp_py(disp_py), .disp_valid(disp_valid), .disp_source(disp_source),
    .disp_colour(disp_colour), .disp_slider_part(disp_slider_part),
    .disp_slider_fill(disp_slider_fill));

  ofl_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'h1, a, {24'h00_0000, d}, rd_v, err_v);
    chk("write response", 32'h0000_0000, {31'h0, err_v});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'h0, a, 32'h0000_0000, rd_v, err_v);
    chk(nm, exp, rd_v);
  endtask
  task automatic fetch(input logic [8:0] code, input logic ram, input logic [4:0] px);
    @(posedge pclk);
    disp_req <= 1'h1;
    element_property_word <= {3'h0, 2'h2, 4'h3, 4'hC, ram, code};
    disp_px <= px;
    disp_py <= (px == 5'h08 && code == 9'h000 && ram) ? 5'h08 : 5'h00;
    @(posedge pclk);
    disp_req <= 1'h0;
    #1;
    chk("fetch valid", 32'h0000_0001, {31'h0, disp_valid});
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    finish_test;
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rdc("width reset", `OFL_OFF_WIDTH, 32'h0000_0008);
    rdc("mask reset", `OFL_OFF_BIT_MASK, 32'h0000_00FF);
    rdc("address reset", `OFL_OFF_BIT_ADDR, 32'h0000_0000);
    wr(`OFL_OFF_WIDTH, 8'h28);
    rdc("width max", `OFL_OFF_WIDTH, 32'h0000_0020);
    wr(`OFL_OFF_HEIGHT, 8'h03);
    rdc("height min", `OFL_OFF_HEIGHT, 32'h0000_0008);
    host.xfer(1'h1, 8'h24, 32'h0000_0001, rd_v, err_v);
    chk("unmapped error", 32'h0000_0001, {31'h0, err_v});
    host.xfer(1'h1, `OFL_OFF_BIT_ADDR, 32'h0000_0040, rd_v, err_v);
    chk("read only error", 32'h0000_0001, {31'h0, err_v});
    rdc("address kept", `OFL_OFF_BIT_ADDR, 32'h0000_0000);
    rdc("data port read", `OFL_OFF_DATA_PORT, 32'h0000_0000);
    wr(`OFL_OFF_WIDTH, 8'h09);
    wr(`OFL_OFF_HEIGHT, 8'h0B);
    wr(`OFL_OFF_SC_HIGH, 8'h00);
    wr(`OFL_OFF_SC_LOW, 8'h00);
    wr(`OFL_OFF_CODE_LOW, 8'h05);
    rdc("mono base", `OFL_OFF_BIT_ADDR, 32'h0000_01EF);
    wr(`OFL_OFF_CODE_HIGH, 8'h01);
    rdc("code bit 8 base", `OFL_OFF_BIT_ADDR, 32'h0000_64EF);
    for (int i = 0; i < 13; i++) wr(`OFL_OFF_DATA_PORT, 8'h00);
    rdc("burst end", `OFL_OFF_BIT_ADDR, 32'h0000_6557);
    wr(`OFL_OFF_CODE_HIGH, 8'h00);
    wr(`OFL_OFF_SC_LOW, 8'h10);
    wr(`OFL_OFF_CODE_LOW, 8'h03);
    rdc("multi base", `OFL_OFF_BIT_ADDR, 32'h0000_0252);
    wr(`OFL_OFF_CODE_LOW, 8'h12);
    rdc("mono after split", `OFL_OFF_BIT_ADDR, 32'h0000_0D26);
    // stop flag on a 9x9 mono glyph, glyph 1 head cleared first
    wr(`OFL_OFF_SC_LOW, 8'h00);
    wr(`OFL_OFF_HEIGHT, 8'h09);
    wr(`OFL_OFF_CODE_LOW, 8'h01);
    wr(`OFL_OFF_DATA_PORT, 8'h00);
    wr(`OFL_OFF_CODE_HIGH, 8'h80);
    wr(`OFL_OFF_CODE_LOW, 8'h00);
    for (int i = 0; i < 12; i++) wr(`OFL_OFF_DATA_PORT, 8'hFF);
    rdc("stop address", `OFL_OFF_BIT_ADDR, 32'h0000_0060);
    fetch(9'h001, 1'h1, 5'h00);
    chk("next glyph kept", 32'h0000_0003, disp_colour);
    fetch(9'h001, 1'h1, 5'h07);
    chk("write past end", 32'h0000_0003, disp_colour);
    chk("ram source", OFL_SRC_RAM, disp_source);
    fetch(9'h000, 1'h1, 5'h08);
    chk("last pixel", 32'h0000_000C, disp_colour);
    // masked rewrite of row 0
    wr(`OFL_OFF_CODE_HIGH, 8'h00);
    wr(`OFL_OFF_CODE_LOW, 8'h00);
    wr(`OFL_OFF_DATA_PORT, 8'hA5);
    wr(`OFL_OFF_CODE_LOW, 8'h00);
    wr(`OFL_OFF_BIT_MASK, 8'h0F);
    wr(`OFL_OFF_DATA_PORT, 8'hFF);
    for (int i = 0; i < 9; i++) begin
      fetch(9'h000, 1'h1, 5'(i));
      chk("mono pixel", pat[8 - i] ? 32'h0000_000C : 32'h0000_0003, disp_colour);
    end
    // start code 100: glyphs below it multicolour
    wr(`OFL_OFF_BIT_MASK, 8'hFF);
    wr(`OFL_OFF_SC_HIGH, 8'h01);
    wr(`OFL_OFF_CODE_LOW, 8'h00);
    wr(`OFL_OFF_DATA_PORT, 8'h1B);
    for (int i = 0; i < 4; i++) begin
      fetch(9'h000, 1'h1, 5'(i));
      chk("multi pixel", 32'h0000_0008 + i, disp_colour);
    end
    for (int i = 0; i < 8; i++) begin
      fetch(sl_code[i], 1'h0, sl_px[i]);
      chk("slider part", sl_part[i], disp_slider_part);
      chk("slider source", OFL_SRC_GEN, disp_source);
      if (sl_part[i] == 2'h3) chk("slider fill", sl_fill[i], disp_slider_fill);
    end
    fetch(9'h050, 1'h0, 5'h00);
    chk("rom source", OFL_SRC_ROM, disp_source);
    chk("no slider", OFL_SL_NONE, disp_slider_part);
    finish_test;
  end
endmodule
